// [rtl/seq_pkg.sv]
/*
  Shared constants and types of the bus cycle sequencer: the cycle and
  instruction codes, the strobe bundle and the timing counts.
  Assumes one processor T state for each clk edge.
*/
package seq_pkg;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 8;
  // Index of the last T state in one external bus cycle (T1, T2, T3 counted 0 to 2)
  localparam logic [1:0] T_LAST = 2'h2;
  localparam logic [3:0] MC_FIRST = 4'h0;
  localparam logic [19:0] SLEEP_ADDR = 20'h7FFFF;
  localparam logic [7:0] IO_HIGH_BYTE = 8'h00;

  typedef enum logic [3:0] {
    K_ROT_HL = 4'h0,
    K_ROT_IDX = 4'h1,
    K_BIT_HL = 4'h2,
    K_BIT_IDX = 4'h3,
    K_ROT_REG = 4'h4,
    K_BIT_REG = 4'h5,
    K_RST = 4'h6,
    K_SCF = 4'h7,
    K_SLEEP = 4'h8,
    K_IO_PORT_TEST_INSTR = 4'h9,
    K_TST_G = 4'hA,
    K_TST_M = 4'hB,
    K_TST_HL = 4'hC
  } instr_kind_t;

  typedef enum logic [3:0] {
    C_FETCH1 = 4'h0,
    C_FETCH2 = 4'h1,
    C_OPND = 4'h2,
    C_FETCH3 = 4'h3,
    C_RD_TGT = 4'h4,
    C_TI = 4'h5,
    C_WR_TGT = 4'h6,
    C_STK_H = 4'h7,
    C_STK_L = 4'h8,
    C_IORD = 4'h9,
    C_SLP = 4'hA,
    C_END = 4'hB
  } cyc_t;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic memory_request_n;
    logic io_request_n;
    logic first_cycle_indicator_n;
    logic halt_n;
    logic cycle_status;
  } bus_ctrl_t;

  localparam bus_ctrl_t BUS_IDLE = 7'h7F;

endpackage

// [rtl/pin_sync.sv]
/*
  Two-flop synchroniser for a group of pins.
  Assumes the pins may change at any time relative to clk.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync <= '0;
    end
    else
    begin
      meta_q <= pin;
      sync <= meta_q;
    end
  end

endmodule // pin_sync

`default_nettype wire

// [rtl/bus_cycle_sequencer.sv]
/*
  Machine-cycle sequencer: walks one instruction's machine cycles and
  drives address, strobes and data bus for each one.
  Assumes the core hands over the instruction kind, pc_in and pointer_pair
  with start and holds its other register values until done, and that
  memory and I/O answer within the strobes.
*/
// Contract
// RQ1: First opcode fetch: read, memory request, first-cycle low; others high, status low.
// RQ2: Rotate/shift at pointer_pair: fetch, fetch, read, internal, write; five cycles.
// RQ3: Indexed rotate/shift: fetch, fetch, displacement, fetch, read, internal, write.
// RQ4: Second opcode fetch keeps first-cycle low and drives status high.
// RQ5: Displacement is a plain memory read, first-cycle high, status high.
// RQ6: Third opcode fetch after displacement: first-cycle low, status high.
// RQ7: Internal cycle: every strobe high and data bus released.
// RQ8: Bit set/reset at pointer_pair: fetch, fetch, read, internal, write.
// RQ9: Indexed bit set/reset: same seven cycles as indexed rotate.
// RQ10: I/O test ends with I/O read at C, upper address byte zero.
// RQ11: Memory and I/O return or accept data only inside their strobes.
`timescale 1ns/100ps
`default_nettype none

module bus_cycle_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire seq_pkg::instr_kind_t kind,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] sp_in,
  input wire logic [15:0] pointer_pair,
  input wire logic [15:0] index_reg_x,
  input wire logic [15:0] index_reg_y,
  input wire logic use_index_y,
  input wire logic [7:0] c_reg,
  input wire logic [7:0] wr_data,
  input wire logic wake,
  input wire logic [7:0] data_pin_in,
  output logic [19:0] addr,
  output seq_pkg::bus_ctrl_t bus,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic [7:0] rd_data,
  output logic busy,
  output logic done
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN = 3'b010,
    S_SLEEP = 3'b100
  } state_t;

  state_t state_q;
  seq_pkg::instr_kind_t kind_q;
  logic [3:0] mc_q;
  logic [1:0] t_q;
  logic [15:0] pc_q;
  logic [15:0] tgt_q;
  logic [7:0] din_sync;
  seq_pkg::cyc_t cyc;
  logic cyc_last;
  seq_pkg::bus_ctrl_t cyc_strb;
  logic rd_end_q;
  logic disp_end_q;

  // Each instruction as a list of machine-cycle kinds, closed by C_END
  function automatic seq_pkg::cyc_t seq_step(seq_pkg::instr_kind_t k, logic [3:0] mc);
    seq_pkg::cyc_t s [0:7];
    s = '{default: seq_pkg::C_END};
    s[0] = seq_pkg::C_FETCH1; // see RQ1
    case (k)
      seq_pkg::K_ROT_HL, seq_pkg::K_BIT_HL:
      begin
        s[1] = seq_pkg::C_FETCH2; // see RQ2 see RQ8
        s[2] = seq_pkg::C_RD_TGT;
        s[3] = seq_pkg::C_TI;
        s[4] = seq_pkg::C_WR_TGT;
      end
      seq_pkg::K_ROT_IDX, seq_pkg::K_BIT_IDX:
      begin
        s[1] = seq_pkg::C_FETCH2; // see RQ3 see RQ9
        s[2] = seq_pkg::C_OPND;
        s[3] = seq_pkg::C_FETCH3;
        s[4] = seq_pkg::C_RD_TGT;
        s[5] = seq_pkg::C_TI;
        s[6] = seq_pkg::C_WR_TGT;
      end
      seq_pkg::K_ROT_REG, seq_pkg::K_BIT_REG, seq_pkg::K_TST_G:
      begin
        s[1] = seq_pkg::C_FETCH2;
        s[2] = seq_pkg::C_TI;
      end
      seq_pkg::K_RST:
      begin
        s[1] = seq_pkg::C_TI;
        s[2] = seq_pkg::C_TI;
        s[3] = seq_pkg::C_STK_H;
        s[4] = seq_pkg::C_STK_L;
      end
      seq_pkg::K_SLEEP:
      begin
        s[1] = seq_pkg::C_FETCH2;
        s[2] = seq_pkg::C_SLP;
      end
      seq_pkg::K_IO_PORT_TEST_INSTR:
      begin
        s[1] = seq_pkg::C_FETCH2;
        s[2] = seq_pkg::C_OPND;
        s[3] = seq_pkg::C_IORD; // see RQ10
      end
      seq_pkg::K_TST_M:
      begin
        s[1] = seq_pkg::C_FETCH2;
        s[2] = seq_pkg::C_OPND;
      end
      seq_pkg::K_TST_HL:
      begin
        s[1] = seq_pkg::C_FETCH2;
        s[2] = seq_pkg::C_TI;
        s[3] = seq_pkg::C_RD_TGT;
      end
      default:
      begin
        s[1] = seq_pkg::C_END;
      end
    endcase
    return s[mc[2:0]];
  endfunction

  // Strobe levels of each machine-cycle kind
  function automatic seq_pkg::bus_ctrl_t strobes(seq_pkg::cyc_t c);
    case (c)
      seq_pkg::C_FETCH1: return 7'b0101010; // see RQ1
      seq_pkg::C_FETCH2, seq_pkg::C_FETCH3: return 7'b0101011; // see RQ4 see RQ6
      seq_pkg::C_OPND, seq_pkg::C_RD_TGT: return 7'b0101111; // see RQ5
      seq_pkg::C_WR_TGT, seq_pkg::C_STK_H, seq_pkg::C_STK_L: return 7'b1001111;
      seq_pkg::C_IORD: return 7'b0110111; // see RQ10
      seq_pkg::C_SLP: return 7'b1111101;
      default: return seq_pkg::BUS_IDLE; // see RQ7
    endcase
  endfunction

  // Read data is sampled only through the synchroniser
  pin_sync #(
    .WIDTH(8)
  ) u_data_sync (
    .clk(clk),
    .rst(rst),
    .pin(data_pin_in),
    .sync(din_sync)
  );

  // Sleep keeps its bus state until wake
  assign cyc = (state_q == S_RUN) ? seq_step(kind_q, mc_q) :
               (state_q == S_SLEEP) ? seq_pkg::C_SLP : seq_pkg::C_END;
  assign cyc_strb = strobes(cyc);
  // Internal cycles last one T state, bus cycles three
  assign cyc_last = (cyc == seq_pkg::C_TI) || (t_q == seq_pkg::T_LAST);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      kind_q <= seq_pkg::K_SCF;
      mc_q <= seq_pkg::MC_FIRST;
      t_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (start)
          begin
            state_q <= S_RUN;
            kind_q <= kind;
            mc_q <= seq_pkg::MC_FIRST;
            t_q <= 2'h0;
          end
        end
        S_RUN:
        begin
          if (cyc == seq_pkg::C_END)
            state_q <= S_IDLE;
          else if (cyc == seq_pkg::C_SLP)
            state_q <= S_SLEEP;
          else if (cyc_last)
          begin
            mc_q <= mc_q + 4'h1;
            t_q <= 2'h0;
          end
          else
            t_q <= t_q + 2'h1;
        end
        S_SLEEP:
        begin
          if (wake)
            state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Program counter steps past every opcode and operand byte
  always_ff @(posedge clk)
  begin
    if (rst)
      pc_q <= 16'h0000;
    else if (state_q == S_IDLE && start)
      pc_q <= pc_in;
    else if (cyc_last && (cyc == seq_pkg::C_FETCH1 || cyc == seq_pkg::C_FETCH2 ||
             cyc == seq_pkg::C_FETCH3 || cyc == seq_pkg::C_OPND))
      pc_q <= pc_q + 16'h0001;
  end

  // Synced pins lag the bus, so the displacement is added one clock late
  always_ff @(posedge clk)
  begin
    if (rst)
      disp_end_q <= 1'b0;
    else
      disp_end_q <= (cyc == seq_pkg::C_OPND) && cyc_last &&
                    (kind_q == seq_pkg::K_ROT_IDX || kind_q == seq_pkg::K_BIT_IDX);
  end

  // Operand address: pointer_pair, or index plus signed displacement
  always_ff @(posedge clk)
  begin
    if (rst)
      tgt_q <= 16'h0000;
    else if (state_q == S_IDLE && start)
      tgt_q <= pointer_pair;
    else if (disp_end_q)
      tgt_q <= (use_index_y ? index_reg_y : index_reg_x) +
               {{8{din_sync[7]}}, din_sync}; // see RQ3 see RQ9
  end

  // Outputs follow the sequencer state one clock later
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus <= seq_pkg::BUS_IDLE;
      addr <= 20'h00000;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end
    else
    begin
      bus <= strobes(cyc);
      data_oe_n <= 1'b1; // see RQ7
      case (cyc)
        seq_pkg::C_FETCH1, seq_pkg::C_FETCH2, seq_pkg::C_FETCH3, seq_pkg::C_OPND:
          addr <= {4'h0, pc_q};
        seq_pkg::C_RD_TGT:
          addr <= {4'h0, tgt_q}; // see RQ2 see RQ8
        seq_pkg::C_WR_TGT:
        begin
          addr <= {4'h0, tgt_q};
          data_out <= wr_data;
          data_oe_n <= 1'b0;
        end
        seq_pkg::C_STK_H:
        begin
          addr <= {4'h0, sp_in - 16'h0001};
          data_out <= pc_q[15:8];
          data_oe_n <= 1'b0;
        end
        seq_pkg::C_STK_L:
        begin
          addr <= {4'h0, sp_in - 16'h0002};
          data_out <= pc_q[7:0];
          data_oe_n <= 1'b0;
        end
        seq_pkg::C_IORD:
          addr <= {4'h0, seq_pkg::IO_HIGH_BYTE, c_reg}; // see RQ10
        seq_pkg::C_SLP:
          addr <= seq_pkg::SLEEP_ADDR;
        default:
          addr <= addr;
      endcase
    end
  end

  // Read data relies on the far side holding it inside its strobe;
  // captured a clock after the last T state to cover the synchroniser lag
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_end_q <= 1'b0;
    else
      rd_end_q <= (t_q == seq_pkg::T_LAST) && !cyc_strb.rd_n;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= 8'h00;
    else if (rd_end_q)
      rd_data <= din_sync; // see RQ11
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      busy <= (state_q != S_IDLE);
      done <= (state_q == S_RUN) && (cyc == seq_pkg::C_END);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fetch1_strobes_a: assert property (cyc == seq_pkg::C_FETCH1 |=> bus == 7'b0101010) // see RQ1
    else $error("first fetch strobes wrong");
  second_fetch_a: assert property (cyc == seq_pkg::C_FETCH2 |=> // see RQ4
    !bus.first_cycle_indicator_n && bus.cycle_status && addr[15:0] == $past(pc_q))
    else $error("second fetch status wrong");
  disp_read_a: assert property (cyc == seq_pkg::C_OPND |=> // see RQ5
    bus.first_cycle_indicator_n && bus.cycle_status && !bus.rd_n && !bus.memory_request_n)
    else $error("displacement read strobes wrong");
  third_fetch_a: assert property ($past(cyc) == seq_pkg::C_OPND && cyc == seq_pkg::C_FETCH3 // see RQ6
    |=> !bus.first_cycle_indicator_n && bus.cycle_status)
    else $error("third fetch strobes wrong");
  idle_cycle_a: assert property (cyc == seq_pkg::C_TI |=> bus == 7'h7F && data_oe_n) // see RQ7
    else $error("internal cycle not idle");
  hl_rotate_len_a: assert property (start && state_q == S_IDLE && // see RQ2
    (kind == seq_pkg::K_ROT_HL || kind == seq_pkg::K_BIT_HL) |-> ##15 done) // see RQ8
    else $error("pointer_pair sequence length wrong");
  idx_rotate_len_a: assert property (start && state_q == S_IDLE && // see RQ3
    (kind == seq_pkg::K_ROT_IDX || kind == seq_pkg::K_BIT_IDX) |-> ##21 done) // see RQ9
    else $error("indexed sequence length wrong");
  write_back_a: assert property (cyc == seq_pkg::C_WR_TGT |=> // see RQ2
    !bus.wr_n && bus.rd_n && !data_oe_n && addr[15:0] == $past(tgt_q))
    else $error("write back wrong");
  io_test_a: assert property (cyc == seq_pkg::C_IORD |=> !bus.io_request_n && // see RQ10
    bus.memory_request_n && addr[15:0] == {8'h00, $past(c_reg)})
    else $error("io test cycle wrong");

  idx_done_c: cover property (state_q == S_RUN && kind_q == seq_pkg::K_ROT_IDX && cyc == seq_pkg::C_END);
  sleep_c: cover property (state_q == S_SLEEP ##1 wake);
  io_port_test_instr_c: cover property (cyc == seq_pkg::C_IORD ##3 done);
  rst_push_c: cover property (cyc == seq_pkg::C_STK_L);

endmodule // bus_cycle_sequencer

`default_nettype wire

// [dv/mem_io_model.sv]
/*
  Memory and I/O partner model: answers reads inside the strobes and
  logs the last memory write.
  Assumes the sequencer's registered strobes, address and data enable.
*/
`timescale 1ns/100ps
`default_nettype none

module mem_io_model (
  input wire logic clk,
  input wire seq_pkg::bus_ctrl_t bus,
  input wire logic [19:0] addr,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output logic [7:0] pin,
  output logic [19:0] wr_addr_q,
  output logic [7:0] wr_data_q
);
  logic [7:0] last_q = 8'h00;

  // Outside a read the bus floats: toggle so stale data never passes
  always_comb
  begin
    if (!bus.rd_n && !bus.memory_request_n)
      pin = addr[7:0] ^ 8'h5A;
    else if (!bus.rd_n && !bus.io_request_n)
      pin = addr[7:0] ^ 8'hC3;
    else
      pin = ~last_q;
  end

  always_ff @(posedge clk)
    last_q <= pin;

  always_ff @(posedge clk)
  begin
    if (!bus.wr_n && !bus.memory_request_n && !data_oe_n)
    begin
      wr_addr_q <= addr;
      wr_data_q <= data_out;
    end
  end
endmodule // mem_io_model
`default_nettype wire

// [dv/cpu_bus_cycle_sequencer_bench.sv]
/*
  Self-checking bench of the bus cycle sequencer: walks each memory form except K_TST_HL
  cycle by cycle against the expected strobes and addresses.
  Assumes the partner model's data pattern and the one-clock output lag.
*/
`timescale 1ns/100ps
`default_nettype none

module cpu_bus_cycle_sequencer_bench;
  localparam logic [6:0] F1 = 7'h2A, F2 = 7'h2B, RD = 7'h2F, TI = 7'h7F;
  localparam logic [6:0] WR = 7'h4F, IOR = 7'h37, SLEEP_INSTR = 7'h7D;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, use_index_y = 1'b0, wake = 1'b0;
  seq_pkg::instr_kind_t kind = seq_pkg::K_SCF;
  logic [15:0] pc_in = 16'h0000, sp_in = 16'hFF00, pointer_pair = 16'h0000;
  logic [15:0] index_reg_x = 16'h1000, index_reg_y = 16'h7FF0;
  logic [7:0] c_reg = 8'h00, wr_data = 8'h00, pin, data_out, rd_data, wd;
  logic [19:0] addr, wa;
  seq_pkg::bus_ctrl_t bus;
  logic data_oe_n, busy, done;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  bus_cycle_sequencer uut (.clk(clk), .rst(rst), .start(start), .kind(kind),
    .pc_in(pc_in), .sp_in(sp_in), .pointer_pair(pointer_pair),
    .index_reg_x(index_reg_x), .index_reg_y(index_reg_y),
    .use_index_y(use_index_y), .c_reg(c_reg), .wr_data(wr_data), .wake(wake),
    .data_pin_in(pin), .addr(addr), .bus(bus), .data_out(data_out),
    .data_oe_n(data_oe_n), .rd_data(rd_data), .busy(busy), .done(done));

  mem_io_model far (.clk(clk), .bus(bus), .addr(addr), .data_out(data_out),
    .data_oe_n(data_oe_n), .pin(pin), .wr_addr_q(wa), .wr_data_q(wd));

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Address only holds in internal cycles, so it is not compared there
  task automatic cyc(input logic [6:0] b, input logic [19:0] a, input int n);
    repeat (n)
    begin
      @(negedge clk);
      check(bus, b, "strobes");
      if (b != TI)
        check(addr, a, "address");
      check(data_oe_n, b != WR, "data enable");
      check(done, 1'b0, "early done");
      if (b == WR)
        check(data_out, wr_data, "write data");
    end
  endtask

  task automatic go(input seq_pkg::instr_kind_t k);
    kind = k;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic fin(input logic [7:0] rd_exp);
    @(negedge clk);
    check(done, 1'b1, "done pulse");
    check(bus, seq_pkg::BUS_IDLE, "idle strobes");
    check(rd_data, rd_exp, "read data");
  endtask

  task automatic t_hl(input seq_pkg::instr_kind_t k, input logic [15:0] p);
    pc_in = 16'h1230;
    pointer_pair = p;
    wr_data = p[7:0] ^ 8'hFF;
    go(k);
    cyc(F1, 20'h01230, 3);
    cyc(F2, 20'h01231, 3);
    cyc(RD, {4'h0, p}, 3);
    cyc(TI, 20'h00000, 1);
    cyc(WR, {4'h0, p}, 3);
    fin(p[7:0] ^ 8'h5A);
    check(wa, {4'h0, p}, "write address");
    check(wd, wr_data, "logged data");
  endtask

  task automatic t_idx(input seq_pkg::instr_kind_t k, input logic y, input logic [15:0] pc);
    logic [7:0] d;
    logic [15:0] t;
    d = (pc[7:0] + 8'h02) ^ 8'h5A;
    t = (y ? index_reg_y : index_reg_x) + {{8{d[7]}}, d};
    pc_in = pc;
    use_index_y = y;
    wr_data = 8'h3C;
    go(k);
    cyc(F1, {4'h0, pc}, 3);
    cyc(F2, {4'h0, pc + 16'h0001}, 3);
    // A start while busy must leave the sequence untouched
    start = 1'b1;
    cyc(RD, {4'h0, pc + 16'h0002}, 3);
    start = 1'b0;
    cyc(F2, {4'h0, pc + 16'h0003}, 3);
    cyc(RD, {4'h0, t}, 3);
    cyc(TI, 20'h00000, 1);
    cyc(WR, {4'h0, t}, 3);
    fin(t[7:0] ^ 8'h5A);
  endtask

  task automatic t_io_port_test_instr;
    pc_in = 16'h0400;
    c_reg = 8'h9E;
    go(seq_pkg::K_IO_PORT_TEST_INSTR);
    cyc(F1, 20'h00400, 3);
    cyc(F2, 20'h00401, 3);
    cyc(RD, 20'h00402, 3);
    cyc(IOR, {4'h0, 8'h00, c_reg}, 3);
    fin(c_reg ^ 8'hC3);
  endtask

  // Restart pushes the stepped program counter, high byte first
  task automatic t_rst;
    pc_in = 16'h0C00;
    go(seq_pkg::K_RST);
    cyc(F1, 20'h00C00, 3);
    cyc(TI, 20'h00000, 2);
    wr_data = 8'h0C;
    cyc(WR, {4'h0, sp_in - 16'h0001}, 3);
    wr_data = 8'h01;
    cyc(WR, {4'h0, sp_in - 16'h0002}, 3);
    fin(8'h5A);
  endtask

  task automatic t_sleep;
    pc_in = 16'h0800;
    go(seq_pkg::K_SLEEP);
    cyc(F1, 20'h00800, 3);
    cyc(F2, 20'h00801, 3);
    cyc(SLEEP_INSTR, 20'h7FFFF, 8);
    check(busy, 1'b1, "busy asleep");
    wake = 1'b1;
    repeat (4) @(negedge clk);
    wake = 1'b0;
    check(bus, seq_pkg::BUS_IDLE, "awake strobes");
    check(busy, 1'b0, "awake busy");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      $display("ERROR %0t: timeout", $time);
      close_out;
    end
  end

  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_hl(seq_pkg::K_ROT_HL, 16'h4567);
    t_hl(seq_pkg::K_BIT_HL, 16'hBEEF);
    t_idx(seq_pkg::K_ROT_IDX, 1'b0, 16'h20F0);
    t_idx(seq_pkg::K_BIT_IDX, 1'b1, 16'h3010);
    t_io_port_test_instr;
    t_rst;
    t_sleep;
    close_out;
  end
endmodule // cpu_bus_cycle_sequencer_bench
`default_nettype wire
